// *** wdt_map.svh ***
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH
// ***********************************
// Register offsets
// ***********************************
`define WDT_OFS_CLKCTRL0 8'h06
`define WDT_OFS_RESTART 8'h10
`define WDT_OFS_COUNTSTAT 8'h11
`define WDT_OFS_PMODE2 8'h12
`define WDT_OFS_CLKCTRL1 8'h13
`define WDT_OFS_STATUS 8'h14
// ***********************************
// Reset values and field positions
// ***********************************
`define WDT_RST_CLKCTRL0 8'h08
`define WDT_RST_COUNT 15'h7fff
`define WDT_BIT_MAINSTOP 5
`define WDT_BIT_ACTSEL 6
`define WDT_BIT_CPUSUB 7
`define WDT_BIT_PRESCALE 7
`define WDT_BIT_CHGPROT 1
`define WDT_BIT_SRCLOCK 2
`define WDT_BIT_STOPENTRY 0
`define WDT_DIV16 8'h0f
`define WDT_DIV128 8'h7f
`define WDT_DIV2 8'h01
`endif

// *** wdt_pkg.sv ***
`default_nettype none
package wdt_pkg;
  typedef enum logic [1:0] {SRC_DIV16, SRC_DIV128, SRC_SUB2, SRC_OSC} wdt_src_e;
endpackage : wdt_pkg
`default_nettype wire

// *** wdt_tick_if.sv ***
`default_nettype none
interface wdt_tick_if;
  import wdt_pkg::*;
  wdt_src_e src;
  logic halt;
  logic tick;
  modport gen (input src, input halt, output tick);
  modport use_ (output src, output halt, input tick);
endinterface : wdt_tick_if
`default_nettype wire

// *** wdt_tick_gen.sv ***
`include "wdt_map.svh"
`default_nettype none
module wdt_tick_gen
  import wdt_pkg::*;
(
  // Clocking
  input wire logic clk,
  input wire logic sys_rst,
  // Source clock enables
  input wire logic cpuTick,
  input wire logic oscTick,
  // Tick output
  wdt_tick_if.gen tk
);
  logic [7:0] pre_q;
  logic [7:0] pre_d;
  logic tick_q;
  logic tick_d;
  logic [7:0] lim;
  // ***********************************
  // Prescaler
  // ***********************************
  // Phase is never cleared on restart, so period may be one tick short
  always_comb
  begin
    pre_d = pre_q;
    tick_d = 1'b0;
    unique case (tk.src)
      SRC_DIV16: lim = `WDT_DIV16;
      SRC_DIV128: lim = `WDT_DIV128;
      SRC_SUB2: lim = `WDT_DIV2;
      SRC_OSC: lim = 8'h00;
    endcase
    if (tk.src == SRC_OSC)
    begin
      tick_d = oscTick;
    end
    else if (cpuTick && !tk.halt)
    begin
      if (pre_q >= lim)
      begin
        pre_d = 8'h00;
        tick_d = 1'b1;
      end
      else
      begin
        pre_d = pre_q + 8'h01;
      end
    end
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pre_q <= 8'h00;
      tick_q <= 1'b0;
    end
    else
    begin
      pre_q <= pre_d;
      tick_q <= tick_d;
    end
  end
  assign tk.tick = tick_q;
endmodule : wdt_tick_gen
`default_nettype wire

// *** wdt_core.sv ***
`include "wdt_map.svh"
`default_nettype none
module wdt_core
  import wdt_pkg::*;
(
  // Clocking
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // Count sources and power state
  input wire logic cpuTick,
  input wire logic oscTick,
  input wire logic lowPowerState,
  // Shared vector events
  input wire logic oscStopIrq,
  input wire logic voltMonIrq,
  // Outputs
  output logic sharedVectorIrq,
  output logic wdtResetReq,
  output logic stopModeReq,
  output logic wakeFromWdt,
  output logic cpuSubSel,
  output logic mainClockStop
);
  wdt_tick_if tk ();
  logic [7:0] ctrl0_q;
  logic [7:0] ctrl0_d;
  logic [2:0] pm2_q;
  logic [2:0] pm2_d;
  logic pre_q;
  logic pre_d;
  logic [14:0] cnt_q;
  logic [14:0] cnt_d;
  logic unf_q;
  logic unf_d;
  logic irq_q;
  logic irq_d;
  logic rst_q;
  logic rst_d;
  logic stop_q;
  logic stop_d;
  logic [7:0] rd_q;
  logic [7:0] rd_d;
  logic lock;
  wdt_tick_gen u_tick (
    .clk(clk),
    .sys_rst(sys_rst),
    .cpuTick(cpuTick),
    .oscTick(oscTick),
    .tk(tk)
  );
  // ***********************************
  // Source select
  // ***********************************
  assign lock = pm2_q[`WDT_BIT_SRCLOCK];
  always_comb
  begin
    if (lock)
      tk.src = SRC_OSC;
    else if (ctrl0_q[`WDT_BIT_CPUSUB])
      tk.src = SRC_SUB2;
    else if (pre_q)
      tk.src = SRC_DIV128;
    else
      tk.src = SRC_DIV16;
  end
  assign tk.halt = lowPowerState;
  // ***********************************
  // Registers
  // ***********************************
  always_comb
  begin
    ctrl0_d = ctrl0_q;
    pm2_d = pm2_q;
    pre_d = pre_q;
    stop_d = 1'b0;
    if (regWr && regAddr == `WDT_OFS_CLKCTRL0)
    begin
      ctrl0_d = regWrData;
      ctrl0_d[`WDT_BIT_ACTSEL] = regWrData[`WDT_BIT_ACTSEL] | ctrl0_q[`WDT_BIT_ACTSEL];
      if (pm2_q[`WDT_BIT_CHGPROT])
      begin
        ctrl0_d[`WDT_BIT_CPUSUB] = ctrl0_q[`WDT_BIT_CPUSUB];
        ctrl0_d[`WDT_BIT_MAINSTOP] = ctrl0_q[`WDT_BIT_MAINSTOP];
      end
    end
    if (regWr && regAddr == `WDT_OFS_PMODE2)
    begin
      pm2_d = regWrData[2:0];
      pm2_d[`WDT_BIT_SRCLOCK] = regWrData[`WDT_BIT_SRCLOCK] | lock;
    end
    if (regWr && regAddr == `WDT_OFS_COUNTSTAT)
      pre_d = regWrData[`WDT_BIT_PRESCALE];
    if (regWr && regAddr == `WDT_OFS_CLKCTRL1 && !lock)
      stop_d = regWrData[`WDT_BIT_STOPENTRY];
  end
  // ***********************************
  // Counter
  // ***********************************
  always_comb
  begin
    cnt_d = cnt_q;
    unf_d = 1'b0;
    if (regWr && regAddr == `WDT_OFS_RESTART)
      cnt_d = `WDT_RST_COUNT;
    else if (tk.tick)
    begin
      cnt_d = cnt_q - 15'h0001;
      unf_d = (cnt_q == 15'h0000);
    end
    irq_d = (unf_q && !ctrl0_q[`WDT_BIT_ACTSEL]) || oscStopIrq || voltMonIrq;
    rst_d = unf_q && ctrl0_q[`WDT_BIT_ACTSEL];
    rd_d = 8'h00;
    if (regRd)
    begin
      unique case (regAddr)
        `WDT_OFS_CLKCTRL0: rd_d = ctrl0_q;
        `WDT_OFS_COUNTSTAT: rd_d = {pre_q, 2'b00, cnt_q[14:10]};
        `WDT_OFS_PMODE2: rd_d = {5'b0_0000, pm2_q};
        `WDT_OFS_STATUS: rd_d = {7'b000_0000, lowPowerState};
        default: rd_d = 8'h00;
      endcase
    end
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl0_q <= `WDT_RST_CLKCTRL0;
      pm2_q <= 3'b000;
      pre_q <= 1'b0;
      cnt_q <= `WDT_RST_COUNT;
      unf_q <= 1'b0;
      irq_q <= 1'b0;
      rst_q <= 1'b0;
      stop_q <= 1'b0;
      rd_q <= 8'h00;
    end
    else
    begin
      ctrl0_q <= ctrl0_d;
      pm2_q <= pm2_d;
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      unf_q <= unf_d;
      irq_q <= irq_d;
      rst_q <= rst_d;
      stop_q <= stop_d;
      rd_q <= rd_d;
    end
  end
  // ***********************************
  // Outputs
  // ***********************************
  assign regRdData = rd_q;
  assign sharedVectorIrq = irq_q;
  assign wdtResetReq = rst_q;
  assign stopModeReq = stop_q;
  // Wait release never comes from the watchdog
  assign wakeFromWdt = 1'b0;
  assign cpuSubSel = ctrl0_q[`WDT_BIT_CPUSUB];
  assign mainClockStop = ctrl0_q[`WDT_BIT_MAINSTOP];
endmodule : wdt_core
`default_nettype wire

// *** wdt_core_properties.sv ***
`include "wdt_map.svh"
`default_nettype none
module wdt_core_properties (
  // Watched ports
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic oscStopIrq,
  input wire logic voltMonIrq,
  input wire logic sharedVectorIrq,
  input wire logic wdtResetReq,
  input wire logic stopModeReq,
  input wire logic wakeFromWdt,
  input wire logic cpuSubSel,
  input wire logic mainClockStop
);
  // ****
  // Checks
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic cw;
  assign cw = regWr && regAddr == `WDT_OFS_CLKCTRL0;
  chk_wake_off: assert property (!wakeFromWdt) else $error("wake");
  chk_vec_share: assert property (oscStopIrq |=> sharedVectorIrq) else $error("vector");
  chk_volt_share: assert property (voltMonIrq |=> sharedVectorIrq) else $error("volt vector");
  chk_rst_pulse: assert property (wdtResetReq |=> !wdtResetReq) else $error("reset pulse");
  chk_irq_pulse: assert property (sharedVectorIrq && !oscStopIrq
    |=> !sharedVectorIrq) else $error("irq pulse");
  chk_restart_quiet: assert property (regWr && regAddr == `WDT_OFS_RESTART
    |-> ##2 !wdtResetReq [*8]) else $error("restart");
  chk_stop_cause: assert property (stopModeReq |-> $past(regWr) && $past(regWrData[0])
    && $past(regAddr) == `WDT_OFS_CLKCTRL1) else $error("stop");
  chk_main_cause: assert property ($changed(mainClockStop) |-> $past(cw)) else $error("main");
  chk_sub_cause: assert property ($changed(cpuSubSel) |-> $past(cw)) else $error("cpu sel");
  cover property (wdtResetReq);
  cover property (sharedVectorIrq && !$past(oscStopIrq));
  cover property (stopModeReq);
endmodule : wdt_core_properties
bind wdt_core wdt_core_properties chk_u (
  .clk(clk),
  .sys_rst(sys_rst),
  .regAddr(regAddr),
  .regWrData(regWrData),
  .regWr(regWr),
  .oscStopIrq(oscStopIrq),
  .voltMonIrq(voltMonIrq),
  .sharedVectorIrq(sharedVectorIrq),
  .wdtResetReq(wdtResetReq),
  .stopModeReq(stopModeReq),
  .wakeFromWdt(wakeFromWdt),
  .cpuSubSel(cpuSubSel),
  .mainClockStop(mainClockStop)
);
`default_nettype wire

// *** wdt_core_tb.sv ***
`include "wdt_map.svh"
`default_nettype none
module wdt_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; $display("BAD %0t got %h want %h", $time, a, b); end end
  logic clk = 0, sys_rst = 1, regWr = 0, regRd = 0, cpuTick = 1, oscTick = 0;
  logic lowPowerState = 0, oscStopIrq = 0, voltMonIrq = 0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, q;
  logic sharedVectorIrq, wdtResetReq, stopModeReq, cpuSubSel, mainClockStop;
  int num_errors = 0, cmp_count = 0, n, t0;
  always #2 clk = ~clk;
  wdt_core dut_u (
    .clk(clk),
    .sys_rst(sys_rst),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWr(regWr),
    .regRd(regRd),
    .regRdData(regRdData),
    .cpuTick(cpuTick),
    .oscTick(oscTick),
    .lowPowerState(lowPowerState),
    .oscStopIrq(oscStopIrq),
    .voltMonIrq(voltMonIrq),
    .sharedVectorIrq(sharedVectorIrq),
    .wdtResetReq(wdtResetReq),
    .stopModeReq(stopModeReq),
    .wakeFromWdt(),
    .cpuSubSel(cpuSubSel),
    .mainClockStop(mainClockStop)
  );
  // ****
  // Scenarios
  // ****
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regRd <= 1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 0;
    #1 q = regRdData;
  endtask : rd
  task automatic t_regs;
    rd(`WDT_OFS_CLKCTRL0);
    `CHK(q, 8'h08)
    rd(8'h20);
    `CHK(q, 8'h00)
    @(posedge clk) oscStopIrq <= 1;
    @(posedge clk) oscStopIrq <= 0;
    #1 `CHK(sharedVectorIrq, 1'b1)
    @(posedge clk) voltMonIrq <= 1;
    @(posedge clk) voltMonIrq <= 0;
    #1 `CHK(sharedVectorIrq, 1'b1)
  endtask : t_regs
  task automatic t_prot;
    wr(`WDT_OFS_PMODE2, 8'h02);
    wr(`WDT_OFS_CLKCTRL0, 8'ha8);
    `CHK({cpuSubSel, mainClockStop}, 2'b00)
    wr(`WDT_OFS_PMODE2, 8'h00);
    wr(`WDT_OFS_CLKCTRL0, 8'ha8);
    `CHK({cpuSubSel, mainClockStop}, 2'b11)
    // Sub clock /2 gives about 1050 ticks here; /16 would still read all ones
    wr(`WDT_OFS_RESTART, 8'h00);
    #8400 rd(`WDT_OFS_COUNTSTAT);
    `CHK(q, 8'h1e)
    wr(`WDT_OFS_CLKCTRL0, 8'h08);
  endtask : t_prot
  // About 1040 ticks at /16; /128 would still read all ones
  task automatic t_div16;
    wr(`WDT_OFS_COUNTSTAT, 8'h80);
    rd(`WDT_OFS_COUNTSTAT);
    `CHK(q[7], 1'b1)
    wr(`WDT_OFS_COUNTSTAT, 8'h00);
    wr(`WDT_OFS_RESTART, 8'h00);
    #66400 rd(`WDT_OFS_COUNTSTAT);
    `CHK(q, 8'h1e)
  endtask : t_div16
  task automatic t_lock;
    wr(`WDT_OFS_CLKCTRL1, 8'h01);
    `CHK(stopModeReq, 1'b1)
    wr(`WDT_OFS_PMODE2, 8'h04);
    wr(`WDT_OFS_PMODE2, 8'h00);
    rd(`WDT_OFS_PMODE2);
    `CHK(q, 8'h04)
    wr(`WDT_OFS_CLKCTRL1, 8'h01);
    `CHK(stopModeReq, 1'b0)
  endtask : t_lock
  // Oscillator ticks every cycle, so the period is exact in cycles
  task automatic t_unf;
    @(posedge clk);
    oscTick <= 1;
    lowPowerState <= 1;
    wr(`WDT_OFS_RESTART, 8'h00);
    for (n = 0; sharedVectorIrq !== 1'b1 && n < 40000; n++) #4;
    `CHK(n >= 32768 && n <= 32771, 1'b1)
    t0 = $time;
    #4400 rd(`WDT_OFS_COUNTSTAT);
    `CHK(q, 8'h1e)
    wr(`WDT_OFS_CLKCTRL0, 8'h48);
    wr(`WDT_OFS_CLKCTRL0, 8'h08);
    rd(`WDT_OFS_CLKCTRL0);
    `CHK(q, 8'h48)
    for (n = 0; wdtResetReq !== 1'b1 && n < 40000; n++) #4;
    `CHK({wdtResetReq, sharedVectorIrq}, 2'b10)
    `CHK(($time - t0) / 4, 32768)
  endtask : t_unf
  task automatic end_sim;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (8) @(posedge clk);
    sys_rst <= 0;
    t_regs;
    t_prot;
    t_div16;
    t_lock;
    t_unf;
    end_sim;
  end
  initial
  begin
    #400000;
    num_errors++;
    end_sim;
  end
endmodule : wdt_core_tb
`default_nettype wire
